// ### sp_logic_pkg.sv
// Purpose: shared constants and types for the sp-add, pc-relative and logic op unit
// Assumes: 32-bit words; 16-bit encodings sit in the low half of the instruction word
// Notes: wide encodings keep the first halfword in the upper half of the word
package sp_logic_pkg;

    // ************************************************************
    // widths, registers and flag positions
    // ************************************************************
    localparam int WORD_W = 32;
    localparam int HALF_W = 16;
    localparam logic [3:0] REG_SP = 4'hd;
    localparam logic [3:0] REG_PC = 4'hf;
    localparam logic [3:0] TEST_DEST = 4'hf;
    localparam logic [31:0] ALIGN_MASK = 32'hffff_fffc;
    localparam logic [5:0] SHIFT_FULL = 6'h20;
    localparam logic [5:0] SHIFT_LSL_MAX_SP = 6'h03;
    localparam int FLAG_N = 3;
    localparam int FLAG_Z = 2;
    localparam int FLAG_C = 1;
    localparam int FLAG_V = 0;
    localparam logic [3:0] FLAGS_RESET = 4'h0;

    // ************************************************************
    // shift kinds
    // ************************************************************
    localparam logic [1:0] SH_LSL = 2'h0;
    localparam logic [1:0] SH_LSR = 2'h1;
    localparam logic [1:0] SH_ASR = 2'h2;
    localparam logic [1:0] SH_ROR = 2'h3;

    // ************************************************************
    // opcode masks and match values
    // ************************************************************
    localparam logic [15:0] ADDSP_N1_MASK = 16'hff78;
    localparam logic [15:0] ADDSP_N1_VAL = 16'h4468;
    localparam logic [15:0] ADDSP_N2_MASK = 16'hff87;
    localparam logic [15:0] ADDSP_N2_VAL = 16'h4485;
    localparam logic [15:0] PCREL_N_MASK = 16'hf800;
    localparam logic [15:0] PCREL_N_VAL = 16'ha000;
    localparam logic [15:0] ASR_N_MASK = 16'hf800;
    localparam logic [15:0] ASR_N_VAL = 16'h1000;
    localparam logic [15:0] ANDR_N_MASK = 16'hffc0;
    localparam logic [15:0] ANDR_N_VAL = 16'h4000;
    localparam logic [15:0] ADDSP_W_MASK = 16'hffef;
    localparam logic [15:0] ADDSP_W_VAL = 16'heb0d;
    localparam logic [15:0] PCREL_W_MASK = 16'hfbff;
    localparam logic [15:0] PCSUB_W_VAL = 16'hf2af;
    localparam logic [15:0] PCADD_W_VAL = 16'hf20f;
    localparam logic [15:0] ANDI_W_MASK = 16'hfbe0;
    localparam logic [15:0] ANDI_W_VAL = 16'hf000;
    localparam logic [15:0] ANDR_W_MASK = 16'hffe0;
    localparam logic [15:0] ANDR_W_VAL = 16'hea00;

    // ************************************************************
    // decoded operation kinds, one-hot
    // ************************************************************
    typedef enum logic [5:0] {
        KIND_NONE = 6'h01,
        KIND_ADD_SP = 6'h02,
        KIND_PC_REL = 6'h04,
        KIND_AND_IMM = 6'h08,
        KIND_AND_REG = 6'h10,
        KIND_ASR_IMM = 6'h20
    } kind_type;

    // ************************************************************
    // encoding overlays
    // ************************************************************
    typedef struct packed {
        logic [4:0] op_hi;
        logic imm_top;
        logic [4:0] op_mid;
        logic set_flags;
        logic [3:0] first_operand_field;
        logic zero_bit;
        logic [2:0] mid_offset_bits;
        logic [3:0] dest;
        logic [1:0] imm_low2;
        logic [1:0] stype;
        logic [3:0] second_operand_field;
    } wide_type;

    typedef struct packed {
        logic [4:0] op;
        logic [4:0] shift_amount_field;
        logic [2:0] second_operand_field;
        logic [2:0] dest;
    } narrow_shift_type;

    typedef struct packed {
        logic [4:0] op;
        logic [2:0] dest;
        logic [7:0] low_offset_byte;
    } narrow_imm_type;

    typedef struct packed {
        logic [7:0] op;
        logic dest_top;
        logic [3:0] second_operand_field;
        logic [2:0] dest_low;
    } narrow_sp_type;

    typedef struct packed {
        logic [1:0] top;
        logic [1:0] pattern;
        logic [7:0] byte_v;
    } mod_imm_type;

    typedef struct packed {
        logic [4:0] rot;
        logic [6:0] low7;
    } rot_imm_type;

    typedef struct packed {
        logic [1:0] stype;
        logic [5:0] amount;
    } shift_dec_type;

    typedef struct packed {
        logic [31:0] value;
        logic carry;
    } exp_imm_type;

    // ************************************************************
    // carriers
    // ************************************************************
    typedef struct packed {
        logic valid;
        logic wide;
        logic [31:0] instr;
        logic cond_pass;
        logic in_block;
        logic last_in_block;
        logic [31:0] op_a;
        logic [31:0] op_b;
        logic [31:0] sp;
        logic [31:0] pc;
    } issue_type;

    typedef struct packed {
        logic done;
        kind_type kind;
        logic invalid;
        logic reg_we;
        logic [3:0] reg_idx;
        logic pc_we;
        logic flags_we;
        logic [31:0] data;
    } outcome_type;

endpackage : sp_logic_pkg

// ### barrel_shifter.sv
// Purpose: combinational shifter with carry out for lsl, lsr, asr, ror and rrx
// Assumes: amount already decoded; ror with amount zero means rrx
// Notes: amount 32 allowed for lsl, lsr and asr
`timescale 1ns/1ns
module barrel_shifter
    import sp_logic_pkg::*;
(
    input wire logic [31:0] value,
    input wire logic [1:0] stype,
    input wire logic [5:0] amount,
    input wire logic carry_in,
    output logic [31:0] result,
    output logic carry_out
);

    logic [32:0] left_ext;
    logic [32:0] right_ext;
    logic signed [32:0] sign_ext;
    logic [31:0] rotated;

    // shift paths; the lsl, lsr and asr ones have a spare bit that catches the carry
    always_comb begin
        left_ext = {1'b0, value} << amount;
        right_ext = {value, 1'b0} >> amount;
        sign_ext = $signed({value, 1'b0}) >>> amount; // sign copies fill the top
        rotated = (value >> amount[4:0]) | (value << (6'h20 - amount));
    end

    // select by shift kind; zero amount passes value and carry through, except ror, where it does rrx
    always_comb begin
        result = value;
        carry_out = carry_in;
        unique case (stype)
            SH_LSL: begin
                if (amount != '0) begin
                    result = left_ext[31:0];
                    carry_out = left_ext[32];
                end
            end
            SH_LSR: begin
                if (amount != '0) begin
                    result = right_ext[32:1];
                    carry_out = right_ext[0];
                end
            end
            SH_ASR: begin
                if (amount != '0) begin
                    result = sign_ext[32:1];
                    carry_out = sign_ext[0];
                end
            end
            SH_ROR: begin
                if (amount == '0) begin
                    result = {carry_in, value[31:1]};
                    carry_out = value[0];
                end else begin
                    result = rotated;
                    carry_out = rotated[31];
                end
            end
        endcase
    end

endmodule : barrel_shifter

// ### sp_logic_unit.sv
// Purpose: decode and execute sp-add, pc-relative address, and, and asr-immediate ops
// Assumes: core supplies first operand in op_a and second operand in op_b
// Notes: one issue per cycle, outcome registered one cycle later
`timescale 1ns/1ns
module sp_logic_unit
    import sp_logic_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input issue_type issue,
    input wire logic flags_load,
    input wire logic [3:0] flags_value,
    output outcome_type outcome,
    output logic [3:0] program_status_flags
);

    // ************************************************************
    // helper functions
    // ************************************************************

    // shift_field_decoder: type and 5-bit amount to kind and 0..32
    function automatic shift_dec_type shift_field_decoder(input logic [1:0] t,
                                                         input logic [4:0] a);
        shift_dec_type d;
        d.stype = t;
        d.amount = {1'b0, a};
        if ((t == SH_LSR || t == SH_ASR) && a == '0) begin
            d.amount = SHIFT_FULL;
        end
        return d;
    endfunction : shift_field_decoder

    // modified_immediate_expander with carry out
    function automatic exp_imm_type modified_immediate_expander(input logic [11:0] imm12,
                                                                input logic c_in);
        mod_imm_type m;
        rot_imm_type r;
        logic [31:0] base;
        exp_imm_type e;
        m = mod_imm_type'(imm12);
        r = rot_imm_type'(imm12);
        base = {24'h00_0000, 1'b1, r.low7};
        e.carry = c_in;
        e.value = '0;
        if (m.top == 2'h0) begin
            unique case (m.pattern)
                2'h0: e.value = {24'h00_0000, m.byte_v};
                2'h1: e.value = {8'h00, m.byte_v, 8'h00, m.byte_v};
                2'h2: e.value = {m.byte_v, 8'h00, m.byte_v, 8'h00};
                2'h3: e.value = {m.byte_v, m.byte_v, m.byte_v, m.byte_v};
            endcase
        end else begin
            e.value = (base >> r.rot) | (base << (6'h20 - {1'b0, r.rot}));
            e.carry = e.value[31];
        end
        return e;
    endfunction : modified_immediate_expander

    // ************************************************************
    // encoding views and recognition
    // ************************************************************
    logic [15:0] half;
    logic [15:0] hw1;
    wide_type w;
    narrow_shift_type ns;
    narrow_imm_type ni;
    narrow_sp_type nsp;
    logic is_addsp1, is_addsp2, is_addsp3, is_adr1, is_adr2, is_adr3;
    logic is_andi, is_andr1, is_andr2, is_asr, hw2_ok;

    // overlays of the issued word
    assign half = issue.instr[HALF_W-1:0];
    assign hw1 = issue.instr[WORD_W-1:HALF_W];
    assign w = wide_type'(issue.instr);
    assign ns = narrow_shift_type'(half);
    assign ni = narrow_imm_type'(half);
    assign nsp = narrow_sp_type'(half);
    assign hw2_ok = !w.zero_bit;

    // opcode matches; sp form 1 wins over sp form 2
    assign is_addsp1 = !issue.wide && (half & ADDSP_N1_MASK) == ADDSP_N1_VAL;
    assign is_addsp2 = !issue.wide && !is_addsp1 && (half & ADDSP_N2_MASK) == ADDSP_N2_VAL;
    assign is_adr1 = !issue.wide && (half & PCREL_N_MASK) == PCREL_N_VAL;
    assign is_asr = !issue.wide && (half & ASR_N_MASK) == ASR_N_VAL;
    assign is_andr1 = !issue.wide && (half & ANDR_N_MASK) == ANDR_N_VAL;
    assign is_addsp3 = issue.wide && hw2_ok && (hw1 & ADDSP_W_MASK) == ADDSP_W_VAL
                       && !(w.dest == TEST_DEST && w.set_flags);
    assign is_adr2 = issue.wide && hw2_ok && (hw1 & PCREL_W_MASK) == PCSUB_W_VAL;
    assign is_adr3 = issue.wide && hw2_ok && (hw1 & PCREL_W_MASK) == PCADD_W_VAL;
    assign is_andi = issue.wide && hw2_ok && (hw1 & ANDI_W_MASK) == ANDI_W_VAL;
    assign is_andr2 = issue.wide && hw2_ok && (hw1 & ANDR_W_MASK) == ANDR_W_VAL;

    // ************************************************************
    // shifter control and instance
    // ************************************************************
    shift_dec_type sh_dec;
    logic [31:0] sh_out;
    logic sh_carry;

    // shift kind and amount per encoding
    always_comb begin
        sh_dec = '{stype: SH_LSL, amount: '0};
        if (is_addsp3 || is_andr2) begin
            sh_dec = shift_field_decoder(w.stype, {w.mid_offset_bits, w.imm_low2});
        end else if (is_asr) begin
            sh_dec = shift_field_decoder(SH_ASR, ns.shift_amount_field);
        end
    end

    barrel_shifter u_shift (
        .value(issue.op_b),
        .stype(sh_dec.stype),
        .amount(sh_dec.amount),
        .carry_in(program_status_flags[FLAG_C]),
        .result(sh_out),
        .carry_out(sh_carry)
    );

    // ************************************************************
    // execute
    // ************************************************************
    outcome_type out_d, out_q;
    logic [3:0] flags_d, flags_q;
    kind_type kind;
    logic inv, sf, wr_reg, wr_pc, commit;
    logic [3:0] dest;
    logic [31:0] res, imm32, aligned_pc;
    logic [32:0] sum;
    logic c_new, v_new;
    exp_imm_type ex;

    // decode fields, compute result and flag values
    always_comb begin
        kind = KIND_NONE;
        inv = 1'b0;
        sf = 1'b0;
        wr_reg = 1'b0;
        wr_pc = 1'b0;
        dest = '0;
        res = '0;
        imm32 = '0;
        c_new = flags_q[FLAG_C];
        v_new = flags_q[FLAG_V];
        aligned_pc = issue.pc & ALIGN_MASK;
        sum = {1'b0, issue.sp} + {1'b0, sh_out};
        ex = modified_immediate_expander({w.imm_top, w.mid_offset_bits,
                                          w.imm_low2, w.stype, w.second_operand_field},
                                         flags_q[FLAG_C]);
        if (is_addsp1 || is_addsp2 || is_addsp3) begin
            kind = KIND_ADD_SP;
            res = sum[31:0];
            c_new = sum[32];
            v_new = (issue.sp[31] == sh_out[31]) && (sum[31] != issue.sp[31]);
            if (is_addsp1) begin
                dest = {nsp.dest_top, nsp.dest_low};
                inv = dest == REG_PC && issue.in_block && !issue.last_in_block;
            end else if (is_addsp2) begin
                dest = REG_SP;
            end else begin
                dest = w.dest;
                sf = w.set_flags;
                inv = (dest == REG_SP && (sh_dec.stype != SH_LSL
                       || sh_dec.amount > SHIFT_LSL_MAX_SP))
                      || (dest == REG_PC && !w.set_flags)
                      || w.second_operand_field == REG_SP
                      || w.second_operand_field == REG_PC;
            end
            wr_pc = dest == REG_PC;
            wr_reg = dest != REG_PC;
            if (dest == REG_PC) begin
                sf = 1'b0;
            end
        end else if (is_adr1 || is_adr2 || is_adr3) begin
            kind = KIND_PC_REL;
            wr_reg = 1'b1;
            if (is_adr1) begin
                dest = {1'b0, ni.dest};
                imm32 = {22'h00_0000, ni.low_offset_byte, 2'h0};
                res = aligned_pc + imm32;
            end else begin
                dest = w.dest;
                imm32 = {20'h0_0000, w.imm_top, w.mid_offset_bits,
                         w.imm_low2, w.stype, w.second_operand_field};
                inv = dest == REG_SP || dest == REG_PC;
                res = is_adr3 ? aligned_pc + imm32 : aligned_pc - imm32;
            end
        end else if (is_andi) begin
            kind = KIND_AND_IMM;
            dest = w.dest;
            sf = w.set_flags;
            res = issue.op_a & ex.value;
            c_new = ex.carry;
            wr_reg = !(dest == TEST_DEST && w.set_flags);
            inv = dest == REG_SP || (dest == REG_PC && !w.set_flags)
                  || w.first_operand_field == REG_SP || w.first_operand_field == REG_PC;
        end else if (is_andr1 || is_andr2) begin
            kind = KIND_AND_REG;
            res = issue.op_a & sh_out;
            c_new = sh_carry;
            if (is_andr1) begin
                dest = {1'b0, ns.dest};
                sf = !issue.in_block;
                wr_reg = 1'b1;
            end else begin
                dest = w.dest;
                sf = w.set_flags;
                wr_reg = !(dest == TEST_DEST && w.set_flags);
                inv = dest == REG_SP || (dest == REG_PC && !w.set_flags)
                      || w.first_operand_field == REG_SP
                      || w.first_operand_field == REG_PC
                      || w.second_operand_field == REG_SP
                      || w.second_operand_field == REG_PC;
            end
        end else if (is_asr) begin
            kind = KIND_ASR_IMM;
            dest = {1'b0, ns.dest};
            sf = !issue.in_block;
            res = sh_out;
            c_new = sh_carry;
            wr_reg = 1'b1;
        end
    end

    // gate effects on condition, validity and recognition
    always_comb begin
        commit = issue.valid && kind != KIND_NONE && !inv && issue.cond_pass;
        out_d.done = issue.valid;
        out_d.kind = issue.valid ? kind : KIND_NONE;
        out_d.invalid = issue.valid && inv;
        out_d.reg_we = commit && wr_reg;
        out_d.reg_idx = dest;
        out_d.pc_we = commit && wr_pc;
        out_d.flags_we = commit && sf;
        out_d.data = res;
        flags_d = flags_q;
        if (flags_load) begin
            flags_d = flags_value;
        end else if (commit && sf) begin
            flags_d[FLAG_N] = res[31];
            flags_d[FLAG_Z] = res == '0;
            flags_d[FLAG_C] = c_new;
            flags_d[FLAG_V] = v_new;
        end
    end

    // outcome and flag registers
    always_ff @(posedge clk) begin
        if (reset) begin
            out_q <= '{kind: KIND_NONE, default: '0};
            flags_q <= FLAGS_RESET;
        end else begin
            out_q <= out_d;
            flags_q <= flags_d;
        end
    end

    assign outcome = out_q;
    assign program_status_flags = flags_q;

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    logic [31:0] exp_short_pc;
    assign exp_short_pc = (issue.pc & ALIGN_MASK) + {22'h00_0000, half[7:0], 2'h0};

    a_pc_write_quiet: assert property (out_q.pc_we |-> !out_q.flags_we && !out_q.reg_we)
        else $error("pc write came with flag or register write");
    a_short_pc_addr: assert property (issue.valid && issue.cond_pass && is_adr1
        |=> out_q.reg_we && out_q.data == $past(exp_short_pc))
        else $error("short pc-relative result wrong");
    a_pc_rel_flags: assert property (out_q.kind == KIND_PC_REL |-> !out_q.flags_we)
        else $error("pc-relative op updated flags");
    a_wide_pc_dest: assert property (issue.valid && (is_adr2 || is_adr3)
        && (w.dest == REG_SP || w.dest == REG_PC) |=> out_q.invalid && !out_q.reg_we)
        else $error("bad pc-relative dest not refused");
    a_logic_v_kept: assert property (!flags_load && out_d.flags_we
        && (kind == KIND_AND_IMM || kind == KIND_AND_REG || kind == KIND_ASR_IMM)
        |=> flags_q[FLAG_V] == $past(flags_q[FLAG_V]))
        else $error("overflow changed by logic op");
    a_fail_cond_quiet: assert property (issue.valid && !issue.cond_pass
        |=> !out_q.reg_we && !out_q.pc_we && !out_q.flags_we)
        else $error("failed condition still wrote");
    a_test_no_write: assert property (issue.valid && (is_andi || is_andr2)
        && w.dest == TEST_DEST && w.set_flags |=> !out_q.reg_we)
        else $error("test-only compare wrote a register");
    a_nz_follow: assert property (!flags_load && out_d.flags_we
        |=> flags_q[FLAG_N] == out_q.data[31]
            && flags_q[FLAG_Z] == (out_q.data == '0))
        else $error("sign or zero flag mismatch");
    a_block_no_flags: assert property (issue.valid && issue.in_block && (is_asr || is_andr1)
        |=> !out_q.flags_we)
        else $error("short form set flags inside block");
    a_asr_sign: assert property (issue.valid && is_asr && issue.op_b[31]
        |=> out_q.data[31])
        else $error("asr lost sign bit");
    a_invalid_quiet: assert property (out_q.invalid
        |-> !out_q.reg_we && !out_q.pc_we && !out_q.flags_we)
        else $error("invalid encoding had effects");

    c_pc_write: cover property (out_q.pc_we);
    c_test_only: cover property (out_q.flags_we && !out_q.reg_we);
    c_asr_full: cover property (issue.valid && is_asr && ns.shift_amount_field == '0);
    c_invalid: cover property (out_q.invalid);

endmodule : sp_logic_unit

// ### tb_top.sv
// Purpose: self-checking bench for the sp-add, pc-relative and logic op unit
// Assumes: one issue per cycle, outcome one cycle later
// Notes: expected outcomes queued by the driver, popped by the monitor
`timescale 1ns/1ns
module tb_top;
    import sp_logic_pkg::*;
    typedef struct {outcome_type o; bit cd; bit cf; logic [3:0] cx;} note_type;
    logic clk = 0;
    logic reset = 1;
    logic flags_load = 0;
    logic [3:0] flags_value = 4'h0;
    issue_type issue = '0;
    outcome_type outcome;
    logic [3:0] program_status_flags;
    note_type notes[$];
    note_type m;
    int err_total = 0;
    int n_tests = 0;
    int seed = 80748;
    logic [31:0] a, r;
    logic [3:0] cx = 4'h0; // check carry, carry, check overflow, overflow
    logic [32:0] s33;
    sp_logic_unit dut (.clk(clk), .reset(reset), .issue(issue), .flags_load(flags_load),
        .flags_value(flags_value), .outcome(outcome),
        .program_status_flags(program_status_flags));
    // ************************************************************
    // clock, tasks
    // ************************************************************
    always #50 clk = ~clk;
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic summarize;
        if (err_total == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : summarize
    // fresh random operands
    task automatic rnd;
        issue.op_a = $random(seed);
        issue.op_b = $random(seed);
        issue.sp = $random(seed);
        issue.pc = $random(seed);
        r = $random(seed);
        a = {issue.pc[31:2], 2'h0};
    endtask : rnd
    // issue one instruction and note its expected outcome
    task automatic send(input logic w, input logic [31:0] ins, input logic cp, input logic ib,
        input kind_type k, input logic [3:0] wr, input logic [3:0] ri, input logic [31:0] d,
        input bit cd);
        note_type n;
        issue.valid = 1;
        issue.wide = w;
        issue.instr = ins;
        issue.cond_pass = cp;
        issue.in_block = ib;
        n.o = '{1'b1, k, wr[3], wr[2], ri, wr[1], wr[0], d};
        n.cd = cd;
        n.cf = wr[0];
        n.cx = cx;
        notes.push_back(n);
        @(posedge clk);
        #1;
    endtask : send
    // monitor: compare each outcome with the oldest note
    always @(negedge clk) begin
        if (outcome.done === 1'b1) begin
            if (notes.size() == 0) begin
                chk("done", 32'h1, 32'h0);
            end else begin
                m = notes.pop_front();
                chk("kind", 32'(outcome.kind), 32'(m.o.kind));
                chk("invalid", 32'(outcome.invalid), 32'(m.o.invalid));
                chk("reg_we", 32'(outcome.reg_we), 32'(m.o.reg_we));
                chk("pc_we", 32'(outcome.pc_we), 32'(m.o.pc_we));
                chk("flags_we", 32'(outcome.flags_we), 32'(m.o.flags_we));
                if (m.cd) chk("data", outcome.data, m.o.data);
                if (m.cd) chk("reg_idx", 32'(outcome.reg_idx), 32'(m.o.reg_idx));
                if (m.cf) chk("nz", 32'(program_status_flags[3:2]),
                    {30'h0, m.o.data[31], m.o.data == 0});
                if (m.cf && m.cx[3]) chk("carry", 32'(program_status_flags[FLAG_C]),
                    32'(m.cx[2]));
                if (m.cf && m.cx[1]) chk("overflow", 32'(program_status_flags[FLAG_V]),
                    32'(m.cx[0]));
            end
        end
    end
    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        repeat (10) @(posedge clk);
        #1;
        reset = 0;
        for (int i = 0; i < 8; i++) begin
            rnd();
            send(0, {16'h0, 5'h14, 3'(i), r[7:0]}, 1, 0, KIND_PC_REL, 4'h4, 4'(i),
                a + {22'h0, r[7:0], 2'h0}, 1);
        end
        rnd();
        send(1, 32'hf60f_1223, 1, 0, KIND_PC_REL, 4'h4, 4'h2, a + 32'h923, 1);
        send(1, 32'hf6af_1223, 1, 0, KIND_PC_REL, 4'h4, 4'h2, a - 32'h923, 1);
        send(1, 32'hf2af_0d00, 1, 0, KIND_PC_REL, 4'h8, 4'hd, 32'h0, 0);
        for (int s = 0; s < 32; s++) begin
            rnd();
            r = s == 0 ? {32{issue.op_b[31]}} : 32'($signed(issue.op_b) >>> s);
            cx = {1'b1, issue.op_b[(s + 31) % 32], 2'h0};
            send(0, {16'h0, 5'h02, 5'(s), 3'h2, 3'h3}, 1, 1'(s), KIND_ASR_IMM,
                {3'h2, ~1'(s)}, 4'h3, r, 1);
        end
        cx = 4'h0;
        for (int k = 0; k < 4; k++) begin
            rnd();
            send(0, 32'h4008, k[1], k[0], KIND_AND_REG, {1'b0, k[1], 1'b0, k[1] & ~k[0]},
                4'h0, issue.op_a & issue.op_b, k[1]);
        end
        rnd();
        send(0, 32'h4469, 1, 0, KIND_ADD_SP, 4'h4, 4'h1, issue.sp + issue.op_b, 1);
        send(0, 32'h44ef, 1, 0, KIND_ADD_SP, 4'h2, 4'hf, issue.sp + issue.op_b, 1);
        s33 = {1'b0, issue.sp} + {1'b0, issue.op_b};
        cx = {1'b1, s33[32], 1'b1, issue.sp[31] == issue.op_b[31] && s33[31] != issue.sp[31]};
        send(1, 32'heb1d_0102, 1, 0, KIND_ADD_SP, 4'h5, 4'h1, issue.sp + issue.op_b, 1);
        send(1, 32'hf010_0fff, 1, 0, KIND_AND_IMM, 4'h1, 4'hf, issue.op_a & 32'hff, 1);
        send(0, 32'h448d, 1, 0, KIND_ADD_SP, 4'h4, 4'hd, issue.sp + issue.op_b, 1);
        send(0, 32'h4488, 1, 0, KIND_NONE, 4'h0, 4'h0, 32'h0, 0);
        rnd();
        cx = {1'b1, issue.op_b[3], 2'h0};
        send(1, 32'hea10_1112, 1, 0, KIND_AND_REG, 4'h5, 4'h1,
            issue.op_a & (issue.op_b >> 4), 1);
        cx = 4'h8;
        send(1, 32'hf410_0155, 1, 0, KIND_AND_IMM, 4'h5, 4'h1,
            issue.op_a & 32'h00d5_0000, 1);
        cx = 4'h0;
        issue.valid = 0;
        flags_load = 1;
        flags_value = 4'ha;
        @(posedge clk);
        #1;
        flags_load = 0;
        chk("flags", 32'(program_status_flags), 32'ha);
        repeat (3) @(posedge clk);
        if (notes.size() != 0) chk("pending", 32'(notes.size()), 32'h0);
        summarize();
    end
endmodule : tb_top
